// >>> shared/tsr_defs.svh
// constants of the temperature sensor register set
// assumes a 100 MHz system clock and a pointer-addressed serial access port
`ifndef TSR_DEFS_SVH
`define TSR_DEFS_SVH

// register pointers
`define TSR_PTR_RESULT 2'h0
`define TSR_PTR_CONFIG 2'h1
`define TSR_PTR_LOWER 2'h2
`define TSR_PTR_UPPER 2'h3

// reset values
`define TSR_RST_RESULT 16'h0000
`define TSR_RST_CONFIG 16'h0200
`define TSR_RST_LOWER 16'hf600
`define TSR_RST_UPPER 16'h3c00

// field layout
`define TSR_WORD_BITS 5'h10
`define TSR_RSVD_MASK 16'hfff8
`define TSR_MARK_BIT 3
`define TSR_CFG_WR_MASK 16'he780

// mode codes
`define TSR_MODE_OFF 2'h0
`define TSR_MODE_ONE 2'h1

// timing: clock period and conversion periods per rate code
`define TSR_CLK_NS 10
`define TSR_PER0_MS 4000
`define TSR_PER1_MS 1000
`define TSR_PER2_MS 250
`define TSR_PER3_US 125000
`define TSR_NS_PER_MS 1000000
`define TSR_NS_PER_US 1000

// 12-bit signed limits of the normal format
`define TSR_NORM_MAX 13'h07ff
`define TSR_NORM_MIN 13'h1800

`endif

// >>> shared/tsr_pkg.sv
// types shared by the temperature sensor register set
// assumes nothing beyond the constants header
`default_nettype none
package tsr_pkg;

    // operating configuration word, msb first
    typedef struct packed {
        logic int_en;
        logic [1:0] rate_sel;
        logic over_limit_ind;
        logic under_limit_ind;
        logic flag_hold_sel;
        logic [1:0] mode;
        logic wide_range_sel;
        logic [6:0] rsvd;
    } tsr_cfg_t;

    // register access port: one transfer is start, bits, stop
    typedef struct packed {
        logic start;
        logic rnw;
        logic [1:0] ptr;
        logic stop;
        logic bit_vld;
        logic bit_val;
        logic bit_take;
    } tsr_acc_t;

endpackage : tsr_pkg
`default_nettype wire

// >>> src/tsr_regs.sv
// register set and limit compare of a digital temperature sensor
// assumes command framing and device addressing sit outside and hand
// over a pointer, a direction and single data bits, least first
`timescale 1ns/1ps
`default_nettype none
`include "tsr_defs.svh"

module tsr_regs #(
    parameter int PER0_CYC =
        `TSR_PER0_MS * (`TSR_NS_PER_MS / `TSR_CLK_NS),
    parameter int PER1_CYC =
        `TSR_PER1_MS * (`TSR_NS_PER_MS / `TSR_CLK_NS),
    parameter int PER2_CYC =
        `TSR_PER2_MS * (`TSR_NS_PER_MS / `TSR_CLK_NS),
    parameter int PER3_CYC =
        `TSR_PER3_US * `TSR_NS_PER_US / `TSR_CLK_NS,
    parameter int TW = 29
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire tsr_pkg::tsr_acc_t acc,
    output logic rd_bit,
    input wire logic conv_done,
    input wire logic [12:0] conv_value,
    output logic conv_start,
    output logic alert_en,
    output logic over_limit_ind,
    output logic under_limit_ind,
    output logic [15:0] result_word
);

    // keep the threshold reserved bits clear
    function automatic logic [15:0] clr_rsvd(input logic [15:0] w);
        clr_rsvd = w & `TSR_RSVD_MASK;
    endfunction : clr_rsvd

    // compare operand: 13 bits, bit 3 dropped in normal format
    function automatic logic signed [12:0] cmp_val(
        input logic [15:0] w,
        input logic wide
    );
        cmp_val = wide ? w[15:3] : {w[15:4], 1'b0};
    endfunction : cmp_val

    // mask of the low n bits of a word
    function automatic logic [15:0] low_mask(input logic [4:0] n);
        logic [16:0] m;
        m = (17'h00001 << n) - 17'h00001;
        low_mask = m[15:0];
    endfunction : low_mask

    // clamp a 13-bit reading into the 12-bit signed range
    function automatic logic [11:0] sat12(input logic [12:0] v);
        logic signed [12:0] s;
        s = v;
        if (s > $signed(`TSR_NORM_MAX)) begin
            sat12 = 12'h7ff;
        end else if (s < $signed(`TSR_NORM_MIN)) begin
            sat12 = 12'h800;
        end else begin
            sat12 = v[11:0];
        end
    endfunction : sat12

    // register state
    tsr_pkg::tsr_cfg_t cfg_q, cfg_d;
    logic [15:0] lower_q, lower_d;
    logic [15:0] upper_q, upper_d;
    logic [15:0] result_q, result_d;

    // transfer state
    logic active_q;
    logic rnw_q;
    logic [1:0] ptr_q;
    logic [4:0] cnt_q;
    logic [15:0] shreg_q, shreg_d;

    // conversion pacing
    logic [TW-1:0] tmr_q;
    logic start_q;
    logic shot_q;

    // access decode
    wire logic wr_bit_ok;
    wire logic rd_shift_ok;
    wire logic commit;
    wire logic cfg_wr;
    wire logic lower_wr;
    wire logic upper_wr;
    wire logic cfg_rd_start;
    wire logic flag_clr;

    assign wr_bit_ok = active_q && !rnw_q && acc.bit_vld
        && (cnt_q != `TSR_WORD_BITS);
    assign rd_shift_ok = active_q && rnw_q && acc.bit_take;
    assign commit = active_q && !rnw_q && acc.stop;
    assign cfg_wr = commit && (ptr_q == `TSR_PTR_CONFIG);
    assign lower_wr = commit && (ptr_q == `TSR_PTR_LOWER);
    assign upper_wr = commit && (ptr_q == `TSR_PTR_UPPER);
    assign cfg_rd_start = acc.start && acc.rnw
        && (acc.ptr == `TSR_PTR_CONFIG);
    // the snapshot below captures the flags before the clear acts
    assign flag_clr = cfg_rd_start && !cfg_q.flag_hold_sel;

    // received bits sit at the top after cnt shifts; align and merge
    // so a one-byte write changes only the low byte
    wire logic [4:0] gap;
    wire logic [15:0] rx_word;
    wire logic [15:0] rx_mask;

    assign gap = 5'(`TSR_WORD_BITS - cnt_q);
    assign rx_word = shreg_q >> gap;
    assign rx_mask = low_mask(cnt_q);

    function automatic logic [15:0] merge(input logic [15:0] old);
        merge = (old & ~rx_mask) | (rx_word & rx_mask);
    endfunction : merge

    // read mux
    wire logic [15:0] rd_word;

    assign rd_word =
        (acc.ptr == `TSR_PTR_RESULT) ? result_q :
        (acc.ptr == `TSR_PTR_CONFIG) ? 16'(cfg_q) :
        (acc.ptr == `TSR_PTR_LOWER) ? lower_q : upper_q;

    // new conversion result in the selected format
    wire logic [15:0] new_res;
    wire logic signed [12:0] res_c;
    wire logic signed [12:0] low_c;
    wire logic signed [12:0] high_c;
    wire logic below;
    wire logic above;

    assign new_res = cfg_q.wide_range_sel
        ? {conv_value, 3'h0}
        : {sat12(conv_value), 4'h0};
    assign res_c = cmp_val(new_res, cfg_q.wide_range_sel);
    assign low_c = cmp_val(lower_q, cfg_q.wide_range_sel);
    assign high_c = cmp_val(upper_q, cfg_q.wide_range_sel);
    assign below = conv_done && (res_c < low_c);
    assign above = conv_done && (res_c > high_c);

    // configuration next value
    wire logic [15:0] cfg_in;
    wire logic [15:0] cfg_keep;

    assign cfg_in = merge(16'(cfg_q));
    assign cfg_keep = 16'(cfg_q) & ~`TSR_CFG_WR_MASK;

    always_comb begin
        cfg_d = cfg_q;
        if (cfg_wr) begin
            // only enable, rate, hold, mode and format take writes
            cfg_d = tsr_pkg::tsr_cfg_t'(
                (cfg_in & `TSR_CFG_WR_MASK) | cfg_keep);
        end
        cfg_d.rsvd = 7'h00;
        // a crossing in the clearing cycle still sets its flag
        if (flag_clr) begin
            cfg_d.over_limit_ind = 1'b0;
            cfg_d.under_limit_ind = 1'b0;
        end
        if (above) begin
            cfg_d.over_limit_ind = 1'b1;
        end
        if (below) begin
            cfg_d.under_limit_ind = 1'b1;
        end
    end

    // threshold next values
    wire logic [15:0] lower_in;
    wire logic [15:0] upper_in;

    assign lower_in = clr_rsvd(merge(lower_q));
    assign upper_in = clr_rsvd(merge(upper_q));

    always_comb begin
        lower_d = lower_q;
        if (lower_wr) begin
            lower_d = lower_in;
            if (!cfg_q.wide_range_sel) begin
                lower_d[`TSR_MARK_BIT] = lower_q[`TSR_MARK_BIT];
            end
        end
    end

    always_comb begin
        upper_d = upper_q;
        if (upper_wr) begin
            upper_d = upper_in;
            if (!cfg_q.wide_range_sel) begin
                upper_d[`TSR_MARK_BIT] = upper_q[`TSR_MARK_BIT];
            end
        end
    end

    assign result_d = conv_done ? new_res : result_q;

    // shift register: loads on read start, shifts right either way
    always_comb begin
        shreg_d = shreg_q;
        if (acc.start) begin
            shreg_d = acc.rnw ? rd_word : 16'h0000;
        end else if (wr_bit_ok) begin
            shreg_d = {acc.bit_val, shreg_q[15:1]};
        end else if (rd_shift_ok) begin
            shreg_d = {1'b0, shreg_q[15:1]};
        end
    end

    // conversion pacing
    wire logic [TW-1:0] period;
    wire logic continuous;
    wire logic tick;
    wire logic shot_req;

    assign period =
        (cfg_q.rate_sel == 2'h0) ? TW'(PER0_CYC - 1) :
        (cfg_q.rate_sel == 2'h1) ? TW'(PER1_CYC - 1) :
        (cfg_q.rate_sel == 2'h2) ? TW'(PER2_CYC - 1) :
        TW'(PER3_CYC - 1);
    assign continuous = cfg_q.mode[1];
    assign tick = continuous && (tmr_q >= period);
    // one shot fires once per write of the one-shot code
    assign shot_req = cfg_wr
        && (cfg_d.mode == `TSR_MODE_ONE);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_q <= tsr_pkg::tsr_cfg_t'(`TSR_RST_CONFIG);
            lower_q <= `TSR_RST_LOWER;
            upper_q <= `TSR_RST_UPPER;
            result_q <= `TSR_RST_RESULT;
        end else begin
            cfg_q <= cfg_d;
            lower_q <= lower_d;
            upper_q <= upper_d;
            result_q <= result_d;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            active_q <= 1'b0;
            rnw_q <= 1'b0;
            ptr_q <= `TSR_PTR_RESULT;
            shreg_q <= 16'h0000;
        end else begin
            active_q <= acc.start || (active_q && !acc.stop);
            rnw_q <= acc.start ? acc.rnw : rnw_q;
            ptr_q <= acc.start ? acc.ptr : ptr_q;
            shreg_q <= shreg_d;
        end
    end

    // bit count saturates at one word; extra bits are dropped
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 5'h00;
        end else if (acc.start) begin
            cnt_q <= 5'h00;
        end else if (wr_bit_ok) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    // timer restarts whenever conversion is not continuous
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tmr_q <= '0;
        end else if (!continuous || tick) begin
            tmr_q <= '0;
        end else begin
            tmr_q <= tmr_q + TW'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            shot_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            shot_q <= shot_req;
            start_q <= tick || shot_q;
        end
    end

    // outputs
    assign rd_bit = shreg_q[0];
    assign conv_start = start_q;
    assign alert_en = cfg_q.int_en;
    assign over_limit_ind = cfg_q.over_limit_ind;
    assign under_limit_ind = cfg_q.under_limit_ind;
    assign result_word = result_q;

endmodule : tsr_regs
`default_nettype wire

// >>> test/tsr_chk.sv
// port checker of the temperature register set
// assumes a bind from the bench top onto tsr_regs
`timescale 1ns/1ps
`default_nettype none
module tsr_chk (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire tsr_pkg::tsr_acc_t acc,
    input wire logic rd_bit,
    input wire logic conv_done,
    input wire logic [12:0] conv_value,
    input wire logic conv_start,
    input wire logic alert_en,
    input wire logic over_limit_ind,
    input wire logic under_limit_ind,
    input wire logic [15:0] result_word
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // flag clear may land one or two edges after the config read
    wire logic cfg_rd = acc.start && acc.rnw && acc.ptr == 2'h1;
    wire logic in12 = conv_value[12] == conv_value[11];
    property p_rsv; result_word[2:0] == 3'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("result low bits");
    property p_res;
        conv_done && in12 |=> (result_word[15:4] == $past(conv_value[11:0])
            && !result_word[3]) || result_word[15:3] == $past(conv_value);
    endproperty
    a_res: assert property (p_res) else $error("result word");
    property p_alr; $changed(alert_en) |-> $past(acc.stop); endproperty
    a_alr: assert property (p_alr) else $error("alert change");
    property p_ovr; $rose(over_limit_ind) |-> $past(conv_done); endproperty
    a_ovr: assert property (p_ovr) else $error("over set");
    property p_und; $rose(under_limit_ind) |-> $past(conv_done); endproperty
    a_und: assert property (p_und) else $error("under set");
    property p_ocl;
        $fell(over_limit_ind) |-> $past(cfg_rd) || $past(cfg_rd, 2);
    endproperty
    a_ocl: assert property (p_ocl) else $error("over clear");
    property p_ucl;
        $fell(under_limit_ind) |-> $past(cfg_rd) || $past(cfg_rd, 2);
    endproperty
    a_ucl: assert property (p_ucl) else $error("under clear");
    property p_cst; conv_start |=> !conv_start; endproperty
    a_cst: assert property (p_cst) else $error("start pulse");
    property p_rd0; acc.start && acc.rnw |=> !rd_bit; endproperty
    a_rd0: assert property (p_rd0) else $error("read bit0");
    cover property (conv_start);
    cover property ($rose(over_limit_ind));
    cover property ($rose(under_limit_ind));
endmodule : tsr_chk
`default_nettype wire

// >>> test/tsr_host.sv
// host model of the register access port
// assumes the bench calls xfer one transfer at a time
`timescale 1ns/1ps
`default_nettype none
module tsr_host (
    input wire logic sys_clk,
    input wire logic rd_bit,
    output var tsr_pkg::tsr_acc_t acc
);
    initial acc = '0;
    // whole 16-bit word, least bit first
    task automatic xfer(input logic rnw, input logic [1:0] p,
        input logic [15:0] w, output logic [15:0] r);
        r = 16'h0000;
        @(negedge sys_clk);
        acc.start = 1'b1;
        acc.rnw = rnw;
        acc.ptr = p;
        for (int i = 0; i < 16; i++) begin
            @(negedge sys_clk);
            acc.start = 1'b0;
            r[i] = rd_bit;
            acc.bit_vld = !rnw;
            acc.bit_val = w[i];
            acc.bit_take = rnw;
        end
        @(negedge sys_clk);
        acc.bit_vld = 1'b0;
        acc.bit_take = 1'b0;
        acc.stop = 1'b1;
        @(negedge sys_clk);
        acc.stop = 1'b0;
    endtask : xfer
endmodule : tsr_host
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench of the temperature register set
// assumes shortened conversion periods and the host model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("BAD %0t got %h want %h", $time, a, b); end end
module tb_top;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic conv_done = 1'b0;
    logic [12:0] conv_value = 13'h0000;
    tsr_pkg::tsr_acc_t acc;
    logic rd_bit, conv_start, alert_en, over_limit_ind, under_limit_ind;
    logic [15:0] result_word, r;
    int fail_count = 0;
    int n_checks = 0;
    tsr_regs #(.PER0_CYC(40), .PER1_CYC(30), .PER2_CYC(20), .PER3_CYC(10))
        tsr_regs_i (.sys_clk(sys_clk), .nrst(nrst), .acc(acc),
        .rd_bit(rd_bit), .conv_done(conv_done), .conv_value(conv_value),
        .conv_start(conv_start), .alert_en(alert_en),
        .over_limit_ind(over_limit_ind), .under_limit_ind(under_limit_ind),
        .result_word(result_word));
    tsr_host tsr_host_i (.sys_clk(sys_clk), .rd_bit(rd_bit), .acc(acc));
    initial forever #5 sys_clk = ~sys_clk;
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done
    task automatic wr(input logic [1:0] p, input logic [15:0] w);
        tsr_host_i.xfer(1'b0, p, w, r);
    endtask : wr
    task automatic rd(input logic [1:0] p);
        tsr_host_i.xfer(1'b1, p, 16'h0000, r);
    endtask : rd
    task automatic conv(input logic [12:0] v);
        @(negedge sys_clk);
        conv_done = 1'b1;
        conv_value = v;
        @(negedge sys_clk);
        conv_done = 1'b0;
    endtask : conv
    // cycles between two start pulses, bounded
    task automatic gap(output int g);
        for (int k = 0; k < 2; k++) begin
            g = 0;
            do begin
                @(posedge sys_clk);
                #1 g++;
            end while (!conv_start && g < 100);
            // a missing first pulse must fail too, not only the second
            if (g >= 100) begin
                fail_count++;
                $display("BAD %0t no start pulse", $time);
                test_done;
            end
        end
    endtask : gap
    task automatic pulses(output int n);
        n = 0;
        repeat (60) begin
            @(posedge sys_clk);
            #1 n += int'(conv_start);
        end
    endtask : pulses
    task automatic t_reset;
        logic [15:0] e [4] = '{16'h0000, 16'h0200, 16'hf600, 16'h3c00};
        for (int p = 0; p < 4; p++) begin
            rd(2'(p));
            `CHK(r, e[p])
        end
    endtask : t_reset
    task automatic t_mode;
        int n;
        int per [4] = '{40, 30, 20, 10};
        wr(2'h1, 16'hffff);
        `CHK(alert_en, 1'b1)
        rd(2'h1);
        `CHK(r, 16'he780)
        for (int c = 0; c < 4; c++) begin
            wr(2'h1, {1'b0, 2'(c), 13'h0200});
            gap(n);
            `CHK(n, per[c])
        end
        wr(2'h1, 16'h0000);
        `CHK(alert_en, 1'b0)
        pulses(n);
        `CHK(n, 0)
        wr(2'h1, 16'h0100);
        pulses(n);
        `CHK(n, 1)
    endtask : t_mode
    task automatic t_thr;
        wr(2'h1, 16'h0000);
        wr(2'h2, 16'h123f);
        rd(2'h2);
        `CHK(r, 16'h1230)
        wr(2'h1, 16'h0080);
        wr(2'h3, 16'h123f);
        rd(2'h3);
        `CHK(r, 16'h1238)
        conv(13'h1000);
        rd(2'h0);
        `CHK(r, 16'h8000)
        // -4096 lies below the lower limit, so the low flag is up
        `CHK(under_limit_ind, 1'b1)
        rd(2'h1);
        `CHK(r[11], 1'b1)
        `CHK(under_limit_ind, 1'b0)
        wr(2'h1, 16'h0000);
        wr(2'h2, 16'hf600);
        wr(2'h3, 16'h3c00);
        conv(13'h1f60);
        `CHK(result_word, 16'hf600)
    endtask : t_thr
    task automatic t_flags;
        conv(13'h03c0);
        `CHK({over_limit_ind, under_limit_ind}, 2'b00)
        conv(13'h03c1);
        rd(2'h1);
        `CHK(r[12], 1'b1)
        `CHK(over_limit_ind, 1'b0)
        conv(13'h1f5f);
        rd(2'h1);
        `CHK(r[11], 1'b1)
        rd(2'h1);
        `CHK(r[11], 1'b0)
        wr(2'h1, 16'h0400);
        conv(13'h1f5f);
        rd(2'h1);
        rd(2'h1);
        `CHK(r[11], 1'b1)
    endtask : t_flags
    initial begin
        repeat (12) @(negedge sys_clk);
        nrst = 1'b1;
        t_reset;
        t_mode;
        t_thr;
        t_flags;
        test_done;
    end
endmodule : tb_top
bind tsr_regs tsr_chk tsr_chk_i (.sys_clk(sys_clk), .nrst(nrst), .acc(acc),
    .rd_bit(rd_bit), .conv_done(conv_done), .conv_value(conv_value),
    .conv_start(conv_start), .alert_en(alert_en),
    .over_limit_ind(over_limit_ind), .under_limit_ind(under_limit_ind),
    .result_word(result_word));
`default_nettype wire
